// ==== common/ssq_pkg.sv ====
package ssq_pkg;

	// ----------------------------------------
	// Pin synchroniser lanes
	// ----------------------------------------
	localparam int PIN_COUNT = 5;
	localparam int PIN_SCLK = 0;
	localparam int PIN_DIN = 1;
	localparam int PIN_CS_N = 2;
	localparam int PIN_SHUTDOWN_N_N = 3;
	localparam int PIN_COMP = 4;
	// Idle levels: shift clock low, chip select high, shutdown released
	localparam logic [4:0] PIN_IDLE = 5'h0C;

	// ----------------------------------------
	// Control byte layout and counts
	// ----------------------------------------
	localparam logic [3:0] CTRL_BITS = 4'h8;
	localparam logic [3:0] TRACK_AFTER_BIT = 4'h5;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam logic [3:0] COUNT_FIRST = 4'h1;
	localparam int POS_PICK_HI = 6;
	localparam int POS_PICK_LO = 4;
	localparam int POS_POLARITY = 3;
	localparam int POS_PAIRING = 2;
	localparam int POS_POWER_HI = 1;
	localparam int POS_POWER_LO = 0;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [7:0] SHIFT_START = 8'h80;

	// ----------------------------------------
	// Conversion timing in shift-clock falls after hold
	// ----------------------------------------
	localparam logic [4:0] FALL_RESET = 5'h00;
	localparam logic [4:0] FALL_STROBE_END = 5'h01;
	localparam logic [4:0] FALL_FIRST_DECISION = 5'h03;
	localparam logic [4:0] FALL_OVERLAP = 5'h08;
	localparam logic [4:0] FALL_LAST_DECISION = 5'h0E;

	// ----------------------------------------
	// Approximation register
	// ----------------------------------------
	localparam int DECISIONS = 12;
	localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
	localparam logic [11:0] SAR_RESET = 12'h000;

	// ----------------------------------------
	// Power modes
	// ----------------------------------------
	localparam logic [1:0] POWER_DEEP_SLEEP = 2'h0;
	localparam logic [1:0] POWER_QUICK_SLEEP = 2'h1;
	localparam logic [1:0] POWER_LOW_POWER_RUN = 2'h2;
	localparam logic [1:0] POWER_NORMAL = 2'h3;

	// ----------------------------------------
	// Input legs: channels 0..3, bit 4 is the common return
	// ----------------------------------------
	localparam logic [3:0] LEG_CH0 = 4'h1;
	localparam logic [3:0] LEG_CH1 = 4'h2;
	localparam logic [3:0] LEG_CH2 = 4'h4;
	localparam logic [3:0] LEG_CH3 = 4'h8;
	localparam logic [4:0] NEG_COMMON = 5'h10;
	localparam logic [4:0] NEG_CH0 = 5'h01;
	localparam logic [4:0] NEG_CH1 = 5'h02;
	localparam logic [4:0] NEG_CH2 = 5'h04;
	localparam logic [4:0] NEG_CH3 = 5'h08;

	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		CTRL_WAIT = 2'b01,
		CTRL_SHIFT = 2'b10
	} ssq_ctrl_type;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_RUN = 2'b10
	} ssq_conv_type;

endpackage : ssq_pkg

// ==== common/ssq_sar_if.sv ====
interface ssq_sar_if;
	logic clear;
	logic step;
	logic comparator;
	logic [11:0] trial_code;

	modport engine (
		input clear,
		input step,
		input comparator,
		output trial_code
	);

	modport seq (
		output clear,
		output step,
		output comparator,
		input trial_code
	);
endinterface : ssq_sar_if

// ==== tb/ssq_host_model.sv ====
module ssq_host_model
	import ssq_pkg::*;
(
	// Clock
	input wire logic clock,
	// Serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe,
	// Analog side
	input wire logic [11:0] level,
	input wire logic [11:0] dac_code,
	output logic comparator_high
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half period 200 ns, shift clock 2.5 MHz
	localparam int HALF = 8;

	// Comparator: high keeps the trial bit
	assign comparator_high = level >= dac_code;

	initial begin
		cs_n = 1'h1;
		sclk = 1'h0;
		din = 1'h0;
	end

	// Select line
	task automatic select(input logic on);
		@(negedge clock);
		cs_n = !on;
		repeat (HALF) @(negedge clock);
	endtask : select

	// One byte each way, MSB first, sample before the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			din = tx[i];
			repeat (HALF) @(negedge clock);
			rx[i] = dout_oe ? dout : 1'bx;
			sclk = 1'h1;
			repeat (HALF) @(negedge clock);
			sclk = 1'h0;
		end
	endtask : xfer
endmodule : ssq_host_model

// ==== tb/ssq_seq_props.sv ====
module ssq_seq_props
	import ssq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Serial pins
	input wire logic cs_n,
	input wire logic dout_oe,
	input wire logic serial_strobe,
	input wire logic serial_strobe_oe,
	// Front end and status
	input wire logic [11:0] dac_code,
	input wire logic [3:0] positive_leg,
	input wire logic [4:0] negative_leg,
	input wire logic track_enable,
	input wire logic converting,
	input wire logic [1:0] power_mode,
	input wire logic shutdown_active,
	input wire logic result_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_hold;
		!track_enable && serial_strobe && dac_code == SAR_FIRST_TRIAL;
	endsequence
	sequence s_float;
		##[1:6] !dout_oe && !serial_strobe_oe;
	endsequence
	sequence s_drive;
		##[2:7] dout_oe && serial_strobe_oe && !serial_strobe;
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_hold;
		$rose(converting) |-> s_hold;
	endproperty
	property p_float;
		$rose(cs_n) |-> s_float;
	endproperty
	property p_drive;
		$fell(cs_n) |-> s_drive;
	endproperty
	property p_strobe_len;
		$rose(serial_strobe) |-> serial_strobe[*7];
	endproperty
	property p_valid_pulse;
		result_valid |=> !result_valid;
	endproperty
	property p_valid_idle;
		result_valid |-> track_enable && !converting;
	endproperty
	property p_power_run;
		converting |-> power_mode == POWER_NORMAL;
	endproperty
	property p_power_apply;
		$changed(power_mode) |-> !converting;
	endproperty
	property p_legs;
		$onehot(positive_leg) && $onehot(negative_leg) && (positive_leg & negative_leg[3:0]) == 4'h0;
	endproperty
	property p_shutdown_n;
		shutdown_active[*3] |-> !converting && !result_valid;
	endproperty

	a_hold: assert property (p_hold) else $error("hold entry wrong");
	a_float: assert property (p_float) else $error("outputs not floated");
	a_drive: assert property (p_drive) else $error("outputs not driven");
	a_strobe_len: assert property (p_strobe_len) else $error("strobe short");
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid long");
	a_valid_idle: assert property (p_valid_idle) else $error("no track at end");
	a_power_run: assert property (p_power_run) else $error("power not normal");
	a_power_apply: assert property (p_power_apply) else $error("power early");
	a_legs: assert property (p_legs) else $error("legs not one-hot");
	a_shutdown_n: assert property (p_shutdown_n) else $error("shutdown ignored");
endmodule : ssq_seq_props

bind ssq_sequencer ssq_seq_props i_ssq_seq_props (
	.clock(clock),
	.nrst(nrst),
	.cs_n(cs_n),
	.dout_oe(dout_oe),
	.serial_strobe(serial_strobe),
	.serial_strobe_oe(serial_strobe_oe),
	.dac_code(dac_code),
	.positive_leg(positive_leg),
	.negative_leg(negative_leg),
	.track_enable(track_enable),
	.converting(converting),
	.power_mode(power_mode),
	.shutdown_active(shutdown_active),
	.result_valid(result_valid)
);

// ==== tb/tb_top.sv ====
module tb_top
	import ssq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock, nrst, cs_n, sclk, din, shutdown_n, comparator_high;
	logic dout, dout_oe, serial_strobe, serial_strobe_oe, track_enable, converting;
	logic shutdown_active, pick_invalid, result_valid;
	logic [11:0] dac_code, last_result, level;
	logic [3:0] positive_leg;
	logic [4:0] negative_leg;
	logic [1:0] power_mode;
	logic [7:0] rx0, rx1, rx2, ctrl_byte;
	wire [9:0] legs_seen = {pick_invalid, positive_leg, negative_leg};
	int n_mismatch = 0;
	int compares = 0;
	int n_valid = 0;
	int v;

`define CHECK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
	end \
end

	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	ssq_sequencer i_ssq_sequencer (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout), .dout_oe(dout_oe), .serial_strobe(serial_strobe),
		.serial_strobe_oe(serial_strobe_oe), .shutdown_n(shutdown_n),
		.comparator_high(comparator_high), .dac_code(dac_code), .positive_leg(positive_leg),
		.negative_leg(negative_leg), .track_enable(track_enable), .converting(converting),
		.power_mode(power_mode), .shutdown_active(shutdown_active),
		.pick_invalid(pick_invalid), .last_result(last_result), .result_valid(result_valid));

	ssq_host_model i_ssq_host_model (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .level(level), .dac_code(dac_code),
		.comparator_high(comparator_high));

	always @(posedge clock) begin
		if (result_valid === 1'h1) n_valid++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [9:0] leg_exp(input logic pair, input logic [2:0] pick);
		case ({pair, pick})
			4'h9: return {1'h0, LEG_CH0, NEG_COMMON};
			4'hD: return {1'h0, LEG_CH1, NEG_COMMON};
			4'hA: return {1'h0, LEG_CH2, NEG_COMMON};
			4'hE: return {1'h0, LEG_CH3, NEG_COMMON};
			4'h1: return {1'h0, LEG_CH0, NEG_CH1};
			4'h2: return {1'h0, LEG_CH2, NEG_CH3};
			4'h5: return {1'h0, LEG_CH1, NEG_CH0};
			4'h6: return {1'h0, LEG_CH3, NEG_CH2};
			default: return {1'h1, LEG_CH0, pair ? NEG_COMMON : NEG_CH1};
		endcase
	endfunction : leg_exp

	task automatic close_out;
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	// One framed conversion and read back
	task automatic convert(input logic [7:0] ctrl, input logic [11:0] vin);
		logic [11:0] dec;
		dec = vin ^ (ctrl[3] ? 12'h000 : 12'h800);
		level = vin;
		i_ssq_host_model.select(1'h1);
		i_ssq_host_model.xfer(8'h00, rx0);
		`CHECK({rx0, converting}, 9'h000);
		i_ssq_host_model.xfer(ctrl, rx0);
		repeat (7) @(negedge clock);
		`CHECK({serial_strobe, converting, track_enable}, 3'h6);
		`CHECK(legs_seen, leg_exp(ctrl[2], ctrl[6:4]));
		i_ssq_host_model.xfer(8'h00, rx1);
		i_ssq_host_model.xfer(8'h00, rx2);
		`CHECK({rx1, rx2}, {3'h0, dec, 1'h0});
		`CHECK(last_result, dec);
		`CHECK({power_mode, track_enable}, {ctrl[1:0], 1'h1});
		i_ssq_host_model.select(1'h0);
		`CHECK({dout_oe, serial_strobe_oe}, 2'h0);
	endtask : convert

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'h0;
		shutdown_n = 1'h1;
		level = 12'h000;
		repeat (5) @(negedge clock);
		nrst = 1'h1;
		@(negedge clock);
		`CHECK({serial_strobe, dout, track_enable, power_mode, pick_invalid}, 6'h0E);
		for (int i = 0; i < 16; i++) begin
			ctrl_byte = {1'h1, i[2:0], i[1], i[3], i[1:0]};
			convert(ctrl_byte, 12'(12'h0A7 * i + 12'h055));
		end
		// Back to back with select held low
		level = 12'hFFF;
		i_ssq_host_model.select(1'h1);
		i_ssq_host_model.xfer(8'h9F, rx0);
		i_ssq_host_model.xfer(8'h00, rx1);
		i_ssq_host_model.xfer(8'h93, rx2);
		level = 12'h000;
		`CHECK({rx1, rx2}, {3'h0, 12'hFFF, 1'h0});
		i_ssq_host_model.xfer(8'h00, rx1);
		i_ssq_host_model.xfer(8'h00, rx2);
		`CHECK({rx1, rx2}, {3'h0, 12'h800, 1'h0});
		// Shutdown in mid conversion
		i_ssq_host_model.xfer(8'h9F, rx0);
		v = n_valid;
		i_ssq_host_model.xfer(8'h00, rx1);
		shutdown_n = 1'h0;
		repeat (8) @(negedge clock);
		`CHECK({converting, shutdown_active, n_valid == v}, 3'h3);
		shutdown_n = 1'h1;
		i_ssq_host_model.select(1'h0);
		convert(8'hEF, 12'h3C4);
		`CHECK(n_valid, 19);
		close_out();
	end

	initial begin
		repeat (100000) @(posedge clock);
		n_mismatch++;
		close_out();
	end
endmodule : tb_top

// ==== verilog/ssq_sar.sv ====
module ssq_sar
	import ssq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Sequencer side
	ssq_sar_if.engine bus
);

	logic [11:0] code;
	logic [11:0] mask;

	// Keep the trial bit when the comparator says input is above it
	wire [11:0] kept = bus.comparator ? code : (code & ~mask);
	wire [11:0] next_code = kept | (mask >> 1);
	wire [11:0] next_mask = mask >> 1;

	assign bus.trial_code = code;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			code <= SAR_RESET;
			mask <= SAR_RESET;
		end else if (bus.clear) begin
			code <= SAR_FIRST_TRIAL;
			mask <= SAR_FIRST_TRIAL;
		end else if (bus.step) begin
			code <= next_code;
			mask <= next_mask;
		end
	end

endmodule : ssq_sar

// ==== verilog/ssq_sequencer.sv ====
// How it works
// - First one bit after chip select falls is the start bit; falling select starts nothing.
// - Zero bits before the start bit are ignored without any state change.
// - Each rising shift-clock edge with select low captures one input bit, from the start bit to the eighth.
// - Tracking is on whenever no conversion runs; the falling edge after the fifth control bit does not start it early.
// - Hold and conversion begin on the falling edge after the eighth control bit.
// - Single-ended uses common return; differential draws legs from fixed pairs.
// - Single-ended picks 001,101,010,110 select channels 0,1,2,3 against common.
// - Differential picks 001,010,101,110 give 0/1, 2/3, 1/0, 3/2 legs.
// - Strobe is high for one shift-clock period right after the control byte.
// - Twelve approximation decisions, one per falling edge, shown MSB first on output.
// - Read bytes carry three zeros, twelve result bits, one zero.
// - Unipolar result is straight binary, bipolar result is two's complement.
// - Select high floats data and strobe; after select falls strobe drives low.
// - A new start bit is taken once result bit six has been shifted out.
// - A started conversion always completes unless shutdown is asserted.
// - With select held low a conversion can follow every 16 shift clocks.
// - At conversion end the hold capacitor reconnects to the positive leg.
// - Control byte: start, three pick bits, polarity, pairing, two power bits.
// - Polarity one is unipolar; pairing one is single-ended, zero differential.
// - Power mode applies after the conversion ends if no control byte is shifting in then; shutdown acts at once.
// - After reset: normal mode, strobe low, zeros on the data output.
module ssq_sequencer
	import ssq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Serial pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	// Serial pins to the host
	output logic dout,
	output logic dout_oe,
	output logic serial_strobe,
	output logic serial_strobe_oe,
	// Hardware shutdown pin
	input wire logic shutdown_n,
	// Analog front end
	input wire logic comparator_high,
	output logic [11:0] dac_code,
	output logic [3:0] positive_leg,
	output logic [4:0] negative_leg,
	output logic track_enable,
	output logic converting,
	// Status
	output logic [1:0] power_mode,
	output logic shutdown_active,
	output logic pick_invalid,
	output logic [11:0] last_result,
	output logic result_valid
);

	// ----------------------------------------
	// Leg decode
	// ----------------------------------------
	function automatic logic [9:0] leg_decode(input logic [2:0] pick, input logic single);
		logic [9:0] legs;
		legs = {1'b1, LEG_CH0, single ? NEG_COMMON : NEG_CH1};
		if (single) begin
			unique case (pick)
				3'h1: legs = {1'b0, LEG_CH0, NEG_COMMON};
				3'h5: legs = {1'b0, LEG_CH1, NEG_COMMON};
				3'h2: legs = {1'b0, LEG_CH2, NEG_COMMON};
				3'h6: legs = {1'b0, LEG_CH3, NEG_COMMON};
				default: legs = {1'b1, LEG_CH0, NEG_COMMON};
			endcase
		end else begin
			unique case (pick)
				3'h1: legs = {1'b0, LEG_CH0, NEG_CH1};
				3'h2: legs = {1'b0, LEG_CH2, NEG_CH3};
				3'h5: legs = {1'b0, LEG_CH1, NEG_CH0};
				3'h6: legs = {1'b0, LEG_CH3, NEG_CH2};
				default: legs = {1'b1, LEG_CH0, NEG_CH1};
			endcase
		end
		return legs;
	endfunction : leg_decode

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [PIN_COUNT-1:0] pins;
	wire [PIN_COUNT-1:0] pins_raw = {comparator_high, shutdown_n, cs_n, din, sclk};

	ssq_sync u_sync (
		.clock(clock),
		.nrst(nrst),
		.pins_raw(pins_raw),
		.pins(pins)
	);

	wire sclk_s = pins[PIN_SCLK];
	wire din_s = pins[PIN_DIN];
	wire cs_n_s = pins[PIN_CS_N];
	wire shutdown_n_n_s = pins[PIN_SHUTDOWN_N_N];
	wire comp_s = pins[PIN_COMP];

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic sclk_prev;
	logic cs_n_prev;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sclk_prev <= PIN_IDLE[PIN_SCLK];
			cs_n_prev <= PIN_IDLE[PIN_CS_N];
		end else begin
			sclk_prev <= sclk_s;
			cs_n_prev <= cs_n_s;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_prev;
	wire sclk_fall = ~sclk_s & sclk_prev;
	wire cs_fall = ~cs_n_s & cs_n_prev;
	wire halt = ~shutdown_n_n_s;

	// ----------------------------------------
	// State
	// ----------------------------------------
	ssq_ctrl_type ctrl_state;
	ssq_conv_type conv_state;
	logic [3:0] bit_count;
	logic [7:0] shift_reg;
	logic [7:0] config_byte;
	logic [4:0] fall_count;
	logic [11:0] result_shift;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	wire running = conv_state == CONV_RUN;
	wire shifting = ctrl_state == CTRL_SHIFT;
	wire shift_edge = sclk_rise & ~cs_n_s;
	wire start_ok = ~running | (fall_count >= FALL_OVERLAP);
	wire take_start = shift_edge & ~shifting & din_s & start_ok & ~halt;
	wire take_bit = shift_edge & shifting & (bit_count != CTRL_BITS);
	wire byte_done = shifting & (bit_count == CTRL_BITS);
	wire launch = sclk_fall & byte_done & ~cs_n_s & ~halt;
	wire track_edge = sclk_fall & shifting & (bit_count == TRACK_AFTER_BIT);
	wire [2:0] bit_index = 3'(CTRL_BITS - COUNT_FIRST - bit_count);

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	wire [4:0] next_fall = 5'(fall_count + 5'h01);
	wire conv_fall = sclk_fall & running & ~halt;
	wire in_window = (next_fall >= FALL_FIRST_DECISION) & (next_fall <= FALL_LAST_DECISION);
	wire decide = conv_fall & in_window;
	wire finish = conv_fall & (next_fall == FALL_LAST_DECISION);
	wire strobe_end = conv_fall & (next_fall == FALL_STROBE_END);
	wire power_apply = finish & ~shifting;
	wire pick_live = shifting | running;

	// ----------------------------------------
	// Result and leg selection
	// ----------------------------------------
	wire bipolar = ~config_byte[POS_POLARITY];
	wire first_decision = next_fall == FALL_FIRST_DECISION;
	wire result_bit = comp_s ^ (bipolar & first_decision);
	wire [7:0] leg_source = running ? config_byte : shift_reg;
	wire [9:0] legs = leg_decode(leg_source[POS_PICK_HI:POS_PICK_LO], leg_source[POS_PAIRING]);
	wire [11:0] next_result = {result_shift[10:0], result_bit};
	wire [1:0] chosen_power = config_byte[POS_POWER_HI:POS_POWER_LO];

	// ----------------------------------------
	// Control byte reception
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst || halt || cs_n_s || launch) begin
			ctrl_state <= CTRL_WAIT;
		end else if (take_start) begin
			ctrl_state <= CTRL_SHIFT;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst || halt || cs_n_s || launch) begin
			bit_count <= COUNT_RESET;
		end else if (take_start) begin
			bit_count <= COUNT_FIRST;
		end else if (take_bit) begin
			bit_count <= 4'(bit_count + COUNT_FIRST);
		end
	end

	// Bits land at their final position so fields are usable early
	always_ff @(posedge clock) begin
		if (!nrst || halt) begin
			shift_reg <= SHIFT_RESET;
		end else if (take_start) begin
			shift_reg <= SHIFT_START;
		end else if (take_bit) begin
			shift_reg[bit_index] <= din_s;
		end
	end

	// ----------------------------------------
	// Conversion sequencing
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst || halt) begin
			conv_state <= CONV_IDLE;
		end else if (launch) begin
			conv_state <= CONV_RUN;
		end else if (finish) begin
			conv_state <= CONV_IDLE;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst || halt || launch) begin
			fall_count <= FALL_RESET;
		end else if (conv_fall) begin
			fall_count <= next_fall;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			config_byte <= SHIFT_RESET;
		end else if (launch) begin
			config_byte <= shift_reg;
		end
	end

	// ----------------------------------------
	// Track and hold
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst || halt) begin
			track_enable <= 1'b1;
		end else if (launch) begin
			track_enable <= 1'b0;
		end else if (finish) begin
			track_enable <= 1'b1;
		end else if (track_edge && !running) begin
			track_enable <= 1'b1;
		end
	end

	assign converting = running;

	// ----------------------------------------
	// Input legs
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			positive_leg <= LEG_CH0;
			negative_leg <= NEG_CH1;
			pick_invalid <= 1'b0;
		end else begin
			positive_leg <= legs[8:5];
			negative_leg <= legs[4:0];
			pick_invalid <= legs[9] & pick_live;
		end
	end

	// ----------------------------------------
	// Approximation engine
	// ----------------------------------------
	ssq_sar_if sar_bus ();

	assign sar_bus.clear = launch | halt;
	assign sar_bus.step = decide;
	assign sar_bus.comparator = comp_s;
	assign dac_code = sar_bus.trial_code;

	ssq_sar u_sar (
		.clock(clock),
		.nrst(nrst),
		.bus(sar_bus)
	);

	// ----------------------------------------
	// Serial outputs
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst || halt) begin
			dout <= 1'b0;
		end else if (sclk_fall) begin
			dout <= decide ? result_bit : 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst || halt || cs_fall) begin
			serial_strobe <= 1'b0;
		end else if (launch) begin
			serial_strobe <= 1'b1;
		end else if (strobe_end) begin
			serial_strobe <= 1'b0;
		end
	end

	assign dout_oe = ~cs_n_s;
	assign serial_strobe_oe = ~cs_n_s;

	// ----------------------------------------
	// Result capture
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst || halt || launch) begin
			result_shift <= SAR_RESET;
		end else if (decide) begin
			result_shift <= next_result;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			last_result <= SAR_RESET;
			result_valid <= 1'b0;
		end else begin
			result_valid <= finish;
			if (finish) begin
				last_result <= next_result;
			end
		end
	end

	// ----------------------------------------
	// Power mode
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			power_mode <= POWER_NORMAL;
		end else if (take_start) begin
			power_mode <= POWER_NORMAL;
		end else if (power_apply) begin
			power_mode <= chosen_power;
		end
	end

	assign shutdown_active = halt;

endmodule : ssq_sequencer

// ==== verilog/ssq_sync.sv ====
module ssq_sync
	import ssq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Raw pins and filtered levels
	input wire logic [PIN_COUNT-1:0] pins_raw,
	output logic [PIN_COUNT-1:0] pins
);

	logic [PIN_COUNT-1:0] stage1;
	logic [PIN_COUNT-1:0] stage2;
	logic [PIN_COUNT-1:0] stage3;

	// Level changes once stages two and three agree
	wire [PIN_COUNT-1:0] next_pins = (stage2 & stage3) | (pins & (stage2 | stage3));

	always_ff @(posedge clock) begin
		if (!nrst) begin
			stage1 <= PIN_IDLE;
			stage2 <= PIN_IDLE;
			stage3 <= PIN_IDLE;
			pins <= PIN_IDLE;
		end else begin
			stage1 <= pins_raw;
			stage2 <= stage1;
			stage3 <= stage2;
			pins <= next_pins;
		end
	end

endmodule : ssq_sync
